// ===== rtl/idle_powerdown_controller.sv
// Idle and power-down sequencing with the fast irq edge control register
`default_nettype none
module idle_powerdown_controller (
    input wire logic ref_clk,
    input wire logic rst,
    input wire ipc_pkg::ipc_sfr_req_s sfrReq,
    output logic [15:0] sfrRdata,
    input wire logic [15:0] systemConfig,
    input wire ipc_pkg::ipc_instr_s instrReq,
    output logic instrRefused,
    input wire logic nmiPinLevel,
    input wire logic [7:0] fastExtIrqPin,
    input wire logic [7:0] irqEnableBit,
    input wire logic anyIrqReq,
    input wire logic eventXferActive,
    input wire logic eventXferFail,
    input wire logic busPending,
    input wire logic readyEnabled,
    input wire logic readySeenLastAccess,
    input wire logic wakeDelayBelowThr,
    output logic cpuHalt,
    output logic periphClkGate,
    output logic oscPllEnable,
    output logic wakeDelayPullDown,
    output logic wakeDelayPullUp,
    output logic clockGateFlop,
    output logic [7:0] irqRequestSet,
    output logic wakeServiceIrq,
    output logic [2:0] modeState
);
    logic [15:0] edgeCtrl_q, edgeCtrl_d;
    logic [7:0] entryLevel_q, entryLevel_d;
    logic [7:0] fieldOn;
    logic [7:0] wakePins_q, wakePins_d;
    ipc_pkg::ipc_mode_e mode_q, mode_d;
    logic gate_q, gate_d;
    logic pullUp_q, pullUp_d;
    logic svc_q, svc_d;
    logic [15:0] rdata_q, rdata_d;
    logic refused_q, refused_d;
    logic entryOk;
    logic pinWake;
    logic wakeCfg;
    logic busClear;

    // Pins whose edge field is nonzero; a zero field leaves the pin out of
    // entry, wake and the request flags alike
    function automatic logic [7:0] fieldOnMask(logic [15:0] ctrl);
        logic [7:0] mask;
        mask = 8'h00;
        for (int n = 0; n < ipc_pkg::NUM_PINS; n++) begin
            mask[n] = (ctrl[2*n +: 2] != ipc_pkg::EDGE_OFF);
        end
        return mask;
    endfunction : fieldOnMask

    // Both stopped-clock modes; the oscillator stays off in either
    function automatic logic isPowerDown(ipc_pkg::ipc_mode_e m);
        return (m == ipc_pkg::IPC_PD_PROT) || (m == ipc_pkg::IPC_PD_INTR);
    endfunction : isPowerDown

    // Address match for the one register on the special function port
    function automatic logic addrHit(logic [15:0] a);
        return a == ipc_pkg::EDGE_CTRL_ADDR;
    endfunction : addrHit

    // Any mode other than run keeps the CPU from executing
    function automatic logic isHalted(ipc_pkg::ipc_mode_e m);
        return m != ipc_pkg::IPC_RUN;
    endfunction : isHalted

    // Combinational decode of pin levels, used while every clock is stopped
    ipc_pin_wake uPinWake (
        .edgeCtrl(edgeCtrl_q),
        .pinLevel(fastExtIrqPin),
        .entryLevel(entryLevel_q),
        .entryOk(entryOk),
        .wakeReq(pinWake)
    );

    assign wakeCfg = systemConfig[ipc_pkg::WAKE_CFG_BIT];
    // Entry is refused while the bus is pending; an enabled ready never seen refuses it too
    assign busClear = ~busPending
        & ~(readyEnabled & ~readySeenLastAccess);

    // Enabled-field mask, recomputed from the register every cycle
    assign fieldOn = fieldOnMask(edgeCtrl_q);

    // Edge control register writes and reads
    always_comb begin
        edgeCtrl_d = edgeCtrl_q;
        rdata_d = rdata_q;
        if (sfrReq.wrEn && addrHit(sfrReq.addr)) begin
            edgeCtrl_d = sfrReq.wdata;
        end
        if (sfrReq.rdEn) begin
            // Other addresses read as zero so a stray read is harmless
            rdata_d = addrHit(sfrReq.addr) ? edgeCtrl_q : 16'h0000;
        end
    end

    // Main mode sequencer
    always_comb begin
        mode_d = mode_q;
        gate_d = gate_q;
        entryLevel_d = entryLevel_q;
        wakePins_d = wakePins_q;
        svc_d = 1'b0;
        refused_d = 1'b0;
        case (mode_q)
            ipc_pkg::IPC_RUN: begin
                if (instrReq.idleInstr) begin
                    if (busClear) begin
                        mode_d = ipc_pkg::IPC_IDLE;
                    end else begin
                        refused_d = 1'b1;
                    end
                end else if (instrReq.powerDownInstr) begin
                    if (!busClear) begin
                        refused_d = 1'b1;
                    end else if (!wakeCfg) begin
                        if (!nmiPinLevel) begin
                            mode_d = ipc_pkg::IPC_PD_PROT;
                            gate_d = 1'b1;
                        end else begin
                            refused_d = 1'b1;
                        end
                    end else if (entryOk) begin
                        mode_d = ipc_pkg::IPC_PD_INTR;
                        gate_d = 1'b1;
                        entryLevel_d = fastExtIrqPin;
                    end else begin
                        refused_d = 1'b1;
                    end
                end
            end
            ipc_pkg::IPC_IDLE: begin
                // Event transfers are served without waking the CPU unless one fails
                if (eventXferActive && eventXferFail) begin
                    mode_d = ipc_pkg::IPC_RUN;
                end else if (anyIrqReq && !eventXferActive) begin
                    mode_d = ipc_pkg::IPC_RUN;
                end
            end
            ipc_pkg::IPC_PD_PROT: begin
                mode_d = ipc_pkg::IPC_PD_PROT;
            end
            ipc_pkg::IPC_PD_INTR: begin
                // Relies on the source holding the level long enough
                if (pinWake) begin
                    mode_d = ipc_pkg::IPC_WAKE_DLY;
                    // Pins whose edge field is off never raise a request flag; enable bits do not mask it
                    wakePins_d = (fastExtIrqPin ^ entryLevel_q) & fieldOn;
                end
            end
            ipc_pkg::IPC_WAKE_DLY: begin
                // Oscillator settles while the RC network discharges
                if (wakeDelayBelowThr) begin
                    gate_d = 1'b0;
                    mode_d = ipc_pkg::IPC_RUN;
                    svc_d = 1'b1;
                end
            end
            default: begin
                mode_d = ipc_pkg::IPC_RUN;
                gate_d = 1'b0;
            end
        endcase
    end

    // Pull-up on the delay pin follows the wake config after reset
    always_comb begin
        pullUp_d = wakeCfg;
    end

    // Register group: edge control and read data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            edgeCtrl_q <= ipc_pkg::EDGE_CTRL_RESET;
            rdata_q <= 16'h0000;
        end else begin
            edgeCtrl_q <= edgeCtrl_d;
            rdata_q <= rdata_d;
        end
    end

    // Mode group; reset is the only way out of protected power-down
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_q <= ipc_pkg::IPC_RUN;
            gate_q <= 1'b0;
            entryLevel_q <= 8'h00;
            wakePins_q <= 8'h00;
            svc_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            gate_q <= gate_d;
            entryLevel_q <= entryLevel_d;
            wakePins_q <= wakePins_d;
            svc_q <= svc_d;
            refused_q <= refused_d;
        end
    end

    // Pull-up group; off during reset, follows the config bit afterwards
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pullUp_q <= 1'b0;
        end else begin
            pullUp_q <= pullUp_d;
        end
    end

    // Outputs; gate holds the watchdog and all units in power-down
    assign sfrRdata = rdata_q;
    assign instrRefused = refused_q;
    assign modeState = mode_q;
    assign clockGateFlop = gate_q;
    assign periphClkGate = gate_q;
    assign cpuHalt = isHalted(mode_q);
    // Oscillator restarts on the edge that enters the wake delay, the first edge after the wake is seen, before clocks open
    assign oscPllEnable = ~isPowerDown(mode_q);
    assign wakeDelayPullDown = (mode_q == ipc_pkg::IPC_WAKE_DLY);
    assign wakeDelayPullUp = pullUp_q & ~wakeDelayPullDown;
    // Flag is raised for every waking pin; software clears it
    assign irqRequestSet = svc_q ? wakePins_q : 8'h00;
    // Core runs the next instruction first, then takes the call
    assign wakeServiceIrq = svc_q & |(wakePins_q & irqEnableBit);
endmodule : idle_powerdown_controller
`default_nettype wire

// ===== shared/ipc_pkg.sv
// Package for the idle and power-down controller: offsets, fields, types
`default_nettype none
package ipc_pkg;
    // Register map on the special function register port
    localparam logic [15:0] EDGE_CTRL_ADDR = 16'hF1C0;
    localparam logic [15:0] EDGE_CTRL_RESET = 16'h0000;
    // Position of the wake configuration bit in the system config register
    localparam int WAKE_CFG_BIT = 5;
    localparam int NUM_PINS = 8;
    // Edge field encodings
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_ANY = 2'h3;
    // Least wake pulse width held by the source and its cycle count
    localparam int WAKE_PULSE_NS = 40;
    localparam int CLK_PERIOD_NS = 8;
    localparam int WAKE_PULSE_CYC =
        (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        IPC_RUN, IPC_IDLE, IPC_PD_PROT, IPC_PD_INTR, IPC_WAKE_DLY
    } ipc_mode_e;

    // Register access strobe group
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ipc_sfr_req_s;

    // Instruction request group from the core
    typedef struct packed {
        logic idleInstr;
        logic powerDownInstr;
    } ipc_instr_s;
endpackage : ipc_pkg
`default_nettype wire

// ===== rtl/ipc_pin_wake.sv
// Per-pin entry permission and level wake decode for the fast irq pins
`default_nettype none
module ipc_pin_wake (
    input wire logic [15:0] edgeCtrl,
    input wire logic [7:0] pinLevel,
    input wire logic [7:0] entryLevel,
    output logic entryOk,
    output logic wakeReq
);
    logic [7:0] blockEntry;
    logic [7:0] wakeBit;

    // Pure level logic: no clock runs while powered down
    always_comb begin
        for (int n = 0; n < ipc_pkg::NUM_PINS; n++) begin
            case (edgeCtrl[2*n +: 2])
                ipc_pkg::EDGE_RISE: begin
                    blockEntry[n] = pinLevel[n];
                    wakeBit[n] = pinLevel[n];
                end
                ipc_pkg::EDGE_FALL: begin
                    blockEntry[n] = ~pinLevel[n];
                    wakeBit[n] = ~pinLevel[n];
                end
                ipc_pkg::EDGE_ANY: begin
                    blockEntry[n] = 1'b0;
                    wakeBit[n] = pinLevel[n] ^ entryLevel[n];
                end
                default: begin
                    blockEntry[n] = 1'b0;
                    wakeBit[n] = 1'b0;
                end
            endcase
        end
    end

    // Enable bits play no part in the wake decode
    assign entryOk = ~|blockEntry;
    assign wakeReq = |wakeBit;
endmodule : ipc_pin_wake
`default_nettype wire

// ===== verification/ipc_monitor.sv
// Checker on the controller ports: mode, gating and refusal relations
`default_nettype none
module ipc_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] systemConfig,
    input wire ipc_pkg::ipc_instr_s instrReq,
    input wire logic nmiPinLevel,
    input wire logic anyIrqReq,
    input wire logic eventXferActive,
    input wire logic eventXferFail,
    input wire logic wakeDelayBelowThr,
    input wire logic instrRefused,
    input wire logic cpuHalt,
    input wire logic clockGateFlop,
    input wire logic oscPllEnable,
    input wire logic wakeDelayPullDown,
    input wire logic [2:0] modeState
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic isRun, isIdle, isProt, isPd, isDly, pdReq;
    // Mode decodes shared by the properties below
    assign isRun = modeState == ipc_pkg::IPC_RUN;
    assign isIdle = modeState == ipc_pkg::IPC_IDLE;
    assign isProt = modeState == ipc_pkg::IPC_PD_PROT;
    assign isPd = isProt || modeState == ipc_pkg::IPC_PD_INTR;
    assign isDly = modeState == ipc_pkg::IPC_WAKE_DLY;
    assign pdReq = instrReq.powerDownInstr && !instrReq.idleInstr && isRun;
    a_halt_not_run: assert property (!isRun == cpuHalt)
        else $error("halt flag disagrees with mode");
    a_idle_irq_exit: assert property (
        isIdle && anyIrqReq && !eventXferActive |=> isRun)
        else $error("idle kept after interrupt");
    a_xfer_keep_idle: assert property (
        isIdle && eventXferActive && !eventXferFail |=> isIdle)
        else $error("idle left during good transfer");
    a_pd_clock_held: assert property (
        isPd |-> clockGateFlop && !oscPllEnable)
        else $error("clock running in power-down");
    a_prot_reset_only: assert property (isProt |=> isProt)
        else $error("protected power-down left without reset");
    a_nmi_high_refuse: assert property (
        pdReq && !systemConfig[ipc_pkg::WAKE_CFG_BIT] && nmiPinLevel
        |=> instrRefused && isRun)
        else $error("protected entry with nmi high");
    a_wake_pull_down: assert property (
        isDly |-> wakeDelayPullDown && oscPllEnable)
        else $error("wake delay without pull-down or oscillator");
    a_gate_until_thr: assert property (
        isDly && !wakeDelayBelowThr |=> isDly && clockGateFlop)
        else $error("clocks released above threshold");
    a_thr_resume: assert property (
        isDly && wakeDelayBelowThr |=> isRun && !clockGateFlop)
        else $error("no resume below threshold");
    c_idle: cover property (isIdle ##1 isRun);
    c_pd_wake: cover property (isPd ##1 isDly);
    c_resume: cover property (isDly ##1 isRun);
endmodule : ipc_monitor
`default_nettype wire

// ===== verification/ipc_partner.sv
// Far side: fast irq pin drivers and the wake delay RC network
`default_nettype none
module ipc_partner #(parameter int DLY = 6) (
    input wire logic ref_clk,
    input wire logic [7:0] pinCmd,
    input wire logic wakeDelayPullDown,
    output logic [7:0] fastExtIrqPin,
    output var logic wakeDelayBelowThr
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    // Bench holds a wake level until run mode, far beyond 40 ns
    assign fastExtIrqPin = pinCmd;
    // Capacitor only discharges while the pull-down is on
    always @(posedge ref_clk) begin
        cnt <= wakeDelayPullDown ? cnt + 1 : 0;
        wakeDelayBelowThr <= #1 wakeDelayPullDown && cnt >= DLY;
    end
endmodule : ipc_partner
`default_nettype wire

// ===== verification/tb_idle_powerdown_controller.sv
// Bench for the idle and power-down controller
`default_nettype none
module tb_idle_powerdown_controller;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 0;
    logic rst = 1;
    ipc_pkg::ipc_sfr_req_s sfrReq = '0;
    ipc_pkg::ipc_instr_s instrReq = '0;
    logic [15:0] systemConfig = 16'h0000;
    logic [15:0] sfrRdata;
    logic [7:0] pinCmd = 8'h00;
    logic [7:0] fastExtIrqPin, irqRequestSet;
    logic [7:0] irqSeen = 8'h00;
    logic [7:0] irqEnable = 8'h00;
    logic readySeen = 0, svcSeen = 0, periphClkGate, wakeServiceIrq;
    logic nmiPinLevel = 1, anyIrqReq = 0, eventXferActive = 0;
    logic eventXferFail = 0, busPending = 0, readyEnabled = 0;
    logic instrRefused, cpuHalt, clockGateFlop, wakeDelayPullDown;
    logic wakeDelayPullUp, wakeDelayBelowThr, oscPllEnable;
    logic [2:0] modeState;
    int errTotal = 0;
    int testsRun = 0;
    int cyc = 0;
    always #4 ref_clk = ~ref_clk;
    ipc_partner #(.DLY(6)) i_ipc_partner(.ref_clk, .pinCmd,
        .wakeDelayPullDown, .fastExtIrqPin, .wakeDelayBelowThr);
    // Enable bits set on one pin only: wake must not depend on them
    idle_powerdown_controller i_idle_powerdown_controller(.ref_clk, .rst,
        .sfrReq, .sfrRdata, .systemConfig, .instrReq, .instrRefused,
        .nmiPinLevel, .fastExtIrqPin, .irqEnableBit(irqEnable), .anyIrqReq,
        .eventXferActive, .eventXferFail, .busPending, .readyEnabled,
        .readySeenLastAccess(readySeen), .wakeDelayBelowThr, .cpuHalt,
        .periphClkGate, .oscPllEnable, .wakeDelayPullDown,
        .wakeDelayPullUp, .clockGateFlop, .irqRequestSet,
        .wakeServiceIrq, .modeState);
    // Wake pulses last one cycle; latch them for a later look
    always @(posedge ref_clk) begin
        irqSeen <= irqSeen | irqRequestSet;
        svcSeen <= svcSeen | wakeServiceIrq;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errTotal++;
            completeRun();
        end
    end
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        testsRun++;
        if (g !== e) begin
            errTotal++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic tick(int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic sfr(logic wr, logic [15:0] a, logic [15:0] d);
        sfrReq = '{wrEn: wr, rdEn: !wr, addr: a, wdata: d};
        tick();
        sfrReq = '0;
        tick();
    endtask : sfr
    task automatic instr(logic pd);
        instrReq = '{idleInstr: !pd, powerDownInstr: pd};
        tick();
        instrReq = '0;
    endtask : instr
    task automatic completeRun();
        if (errTotal == 0 && testsRun > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : completeRun
    initial begin
        tick(10);
        rst = 0;
        tick();
        sfr(0, ipc_pkg::EDGE_CTRL_ADDR, 16'h0000);
        chk("edgeReset", ipc_pkg::EDGE_CTRL_RESET, sfrRdata);
        sfr(1, ipc_pkg::EDGE_CTRL_ADDR, 16'hA5C3);
        sfr(0, ipc_pkg::EDGE_CTRL_ADDR, 16'h0000);
        chk("edgeRw", 16'hA5C3, sfrRdata);
        sfr(0, 16'hF1C2, 16'h0000);
        chk("unmapped", 16'h0000, sfrRdata);
        // Idle: good transfer keeps it, irq or failed transfer ends it
        instr(0);
        chk("idleHalt", 16'h0001, cpuHalt);
        eventXferActive = 1;
        anyIrqReq = 1;
        tick(3);
        chk("xferIdle", ipc_pkg::IPC_IDLE, modeState);
        eventXferActive = 0;
        tick(2);
        chk("irqExit", ipc_pkg::IPC_RUN, modeState);
        anyIrqReq = 0;
        instr(0);
        eventXferActive = 1;
        eventXferFail = 1;
        tick(2);
        chk("xferFail", ipc_pkg::IPC_RUN, modeState);
        eventXferActive = 0;
        eventXferFail = 0;
        // Protected power-down ignores pins and irqs until reset
        instr(1);
        chk("nmiHigh", 16'h0001, instrRefused);
        tick();
        nmiPinLevel = 0;
        instr(1);
        chk("prot", ipc_pkg::IPC_PD_PROT, modeState);
        anyIrqReq = 1;
        pinCmd = 8'hFF;
        tick(8);
        chk("protHeld", ipc_pkg::IPC_PD_PROT, modeState);
        rst = 1;
        tick(2);
        rst = 0;
        anyIrqReq = 0;
        pinCmd = 8'h00;
        nmiPinLevel = 1;
        systemConfig = 16'h0020;
        tick(2);
        chk("protOut", 16'h0001, {modeState, wakeDelayPullUp});
        busPending = 1;
        instr(1);
        chk("busPend", 16'h0001, instrRefused);
        tick();
        busPending = 0;
        readyEnabled = 1;
        instr(1);
        chk("noReady", 16'h0001, instrRefused);
        tick();
        // Ready enabled and seen: entries below are refused only by an active pin
        readySeen = 1;
        // Rise, fall, any on pin 2; pin 0 field stays off
        for (int k = 1; k < 4; k++) begin
            sfr(1, ipc_pkg::EDGE_CTRL_ADDR, 16'(k) << 4);
            irqEnable = (k == 1) ? 8'h04 : 8'h00;
            pinCmd = (k == 1) ? 8'h04 : ((k == 2) ? 8'h00 : 8'h01);
            tick();
            instr(1);
            chk("active", 16'(k != 3), instrRefused);
            // Any edge has already entered; the others retry when inactive
            if (k != 3) begin
                tick();
                pinCmd = (k == 1) ? 8'h01 : 8'h05;
                tick();
                instr(1);
            end
            chk("intr", ipc_pkg::IPC_PD_INTR, modeState);
            chk("pdGate", 16'h0003, {periphClkGate, clockGateFlop});
            pinCmd[0] = 0;
            tick(3);
            chk("offPin", ipc_pkg::IPC_PD_INTR, modeState);
            irqSeen = 8'h00;
            svcSeen = 0;
            pinCmd[2] = !pinCmd[2];
            for (int i = 0; i < 30 && modeState !== 3'h0; i++) tick();
            // Flag pulse is latched one edge after run mode shows
            tick();
            chk("wake", 16'h0004, irqSeen);
            chk("service", 16'(k == 1), svcSeen);
            chk("resume", 16'h0000, {clockGateFlop, modeState});
            chk("clkOn", 16'h0000, periphClkGate);
        end
        completeRun();
    end
endmodule : tb_idle_powerdown_controller
bind idle_powerdown_controller ipc_monitor i_ipc_monitor(.*);
`default_nettype wire
